// file: hdl/status_led_consts.vh
`ifndef STATUS_LED_CONSTS_VH
`define STATUS_LED_CONSTS_VH
// clock rate in hz
`define CLK_HZ 25000000
// blink period for link activity in ms, flash period for bicolour lamps in ms
`define ACT_BLINK_MS 100
`define FLASH_MS 1000
// lamp test time at startup in ms
`define LAMP_TEST_MS 2000
// cycles derived from the times above
`define ACT_HALF_CYC ((`CLK_HZ / 1000) * `ACT_BLINK_MS / 2)
`define FLASH_HALF_CYC ((`CLK_HZ / 1000) * `FLASH_MS / 2)
`define LAMP_TEST_CYC ((`CLK_HZ / 1000) * `LAMP_TEST_MS)
// hardware address layout
`define HW_ADDR_PREFIX_MSB 47
`define HW_ADDR_PREFIX_LSB 24
`define HW_ADDR_SERIAL_MSB 23
`define HW_ADDR_SERIAL_LSB 0
// factory network parameters
`define DEF_IP_ADDR 32'hc0a8010a
`define DEF_NETMASK 32'hffffff00
`define DEF_GATEWAY 32'h00000000
// port speed select codes
`define SPEED_10 1'b0
`define SPEED_100 1'b1
// bicolour lamp codes {red, green}
`define LAMP_OFF 2'b00
`define LAMP_GREEN 2'b01
`define LAMP_RED 2'b10
`define LAMP_BOTH 2'b11
`endif

// file: hdl/encoder_network_status_leds.v
`include "status_led_consts.vh"
`timescale 1ns/1ns
`default_nettype none

// interface notes for whoever integrates this block
// - every input but the asynchronous rstn is a level sampled on the rising clock edge, except message_rx and cfg_we
// - message_rx is one clock high per application message; back to back is fine
// - timeout_cycles counts clocks of silence while online; zero turns it off
// - cfg_we is a one-clock strobe carrying all three network words at once
// - factory_restore wins over cfg_we when both are high in the same clock
// - the hardware address has no write path at all, by construction
// - lamp codes are {red, green}; both bits high only during the lamp test
// - port lamps are single colour: high means lit
// - speed outputs are 1 for the fast rate and 0 for the slow fallback
// - every output leaves a flip-flop, so lamp drivers see no decode glitches
// limitations
// - blink and flash cadences are free running, not restarted per event,
//   so the first lit or dark phase of a flash may be shorter than the rest
// - the lamp test runs once after every reset; it cannot be retriggered
// - the timeout compare uses the live timeout_cycles value, so changing it
//   while online takes effect at once rather than at the next message
// - speed follows partner capability directly; negotiation itself is
//   outside this block and only its outcome is reported here

module encoder_network_status_leds #(
  parameter [23:0] MANUFACTURER_PREFIX = 24'h5a5a5a,       // arbitrary value
  parameter [23:0] UNIT_SERIAL         = 24'h000001,       // arbitrary value
  parameter        ACT_HALF            = `ACT_HALF_CYC,
  parameter        FLASH_HALF          = `FLASH_HALF_CYC,
  parameter        LAMP_TEST           = `LAMP_TEST_CYC,
  parameter        TIMEOUT_W           = 32
) (
  input  wire                 clk,
  input  wire                 rstn,
  input  wire                 first_port_link,
  input  wire                 first_port_activity,
  input  wire                 first_port_partner_fast,
  input  wire                 second_port_link,
  input  wire                 second_port_activity,
  input  wire                 second_port_partner_fast,
  input  wire                 ip_valid,
  input  wire                 ip_conflict,
  input  wire                 fatal_error,
  input  wire                 minor_fault,
  input  wire                 message_rx,
  input  wire [TIMEOUT_W-1:0] timeout_cycles,
  input  wire                 cfg_we,
  input  wire [31:0]          cfg_ip_addr,
  input  wire [31:0]          cfg_netmask,
  input  wire [31:0]          cfg_gateway,
  input  wire                 factory_restore,
  output reg                  first_port_led,
  output reg                  second_port_led,
  output reg                  first_port_speed,
  output reg                  second_port_speed,
  output reg  [1:0]           network_state_indicator,
  output reg  [1:0]           module_health_indicator,
  output reg  [47:0]          hw_addr,
  output reg  [31:0]          ip_addr,
  output reg  [31:0]          netmask,
  output reg  [31:0]          gateway
);

  // network state sequence
  // - no address: lamp dark until an address is held
  // - waiting: address held, no application message yet, green flash
  // - online: at least one message seen, steady green
  // - timed out: silence exceeded the timeout, red flash
  // losing the address from any state returns to no address; a message
  // from the timed out state brings the block back online at once
  // conflict and fatal error do not change the state, they only paint
  // the lamp red, so the previous state shows again once they clear
  localparam NS_NO_ADDR  = 2'd0;
  localparam NS_WAIT_MSG = 2'd1;
  localparam NS_ONLINE   = 2'd2;
  localparam NS_TIMEOUT  = 2'd3;

  reg [31:0]          act_cnt_q;
  reg                 act_ph_q;
  reg [31:0]          flash_cnt_q;
  reg                 flash_ph_q;
  reg [31:0]          test_cnt_q;
  reg                 test_q;
  reg [1:0]           ns_state_q;
  reg [1:0]           ns_state_d;
  reg [TIMEOUT_W-1:0] idle_cnt_q;
  reg [1:0]           ns_lamp_d;
  reg [1:0]           ms_lamp_d;

  // link lamp decode, shared by both ports
  function link_lamp;
    input link;
    input act;
    input phase;
    begin
      if (act)
        link_lamp = phase;
      else
        link_lamp = link;
    end
  endfunction

  // free-running cadence counters; fixed periods keep blink and flash distinct
  // the activity blink is ten times faster than the flash, so an operator
  // can tell traffic from a state flash at a glance
  // counters are 32 bits so the slow flash fits at the full clock rate;
  // the compare uses >= so a shortened period parameter can never hang it
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      act_cnt_q   <= 32'h0;
      act_ph_q    <= 1'b0;
      flash_cnt_q <= 32'h0;
      flash_ph_q  <= 1'b0;
    end else begin
      if (act_cnt_q >= ACT_HALF - 1) begin
        act_cnt_q <= 32'h0;
        act_ph_q  <= ~act_ph_q;
      end else begin
        act_cnt_q <= act_cnt_q + 32'h1;
      end
      if (flash_cnt_q >= FLASH_HALF - 1) begin
        flash_cnt_q <= 32'h0;
        flash_ph_q  <= ~flash_ph_q;
      end else begin
        flash_cnt_q <= flash_cnt_q + 32'h1;
      end
    end
  end

  // startup lamp test window
  // both lamps show both colours so a dead red or green element is visible
  // the counter stops once the window closes, saving toggling power
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      test_cnt_q <= 32'h0;
      test_q     <= 1'b1;
    end else if (test_q) begin
      if (test_cnt_q >= LAMP_TEST - 1)
        test_q <= 1'b0;
      test_cnt_q <= test_cnt_q + 32'h1;
    end
  end

  // network state sequence; a message resets the idle count
  always @* begin
    ns_state_d = ns_state_q;
    case (ns_state_q)
      NS_NO_ADDR: begin
        if (ip_valid)
          ns_state_d = NS_WAIT_MSG;
      end
      NS_WAIT_MSG: begin
        if (message_rx)
          ns_state_d = NS_ONLINE;
      end
      NS_ONLINE: begin
        if (message_rx)
          ns_state_d = NS_ONLINE;
        else if (idle_cnt_q >= timeout_cycles - 1'b1 && timeout_cycles != 0)
          ns_state_d = NS_TIMEOUT;
      end
      NS_TIMEOUT: begin
        if (message_rx)
          ns_state_d = NS_ONLINE;
      end
      default: ns_state_d = NS_NO_ADDR;
    endcase
    if (!ip_valid)
      ns_state_d = NS_NO_ADDR;
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ns_state_q <= NS_NO_ADDR;
      idle_cnt_q <= {TIMEOUT_W{1'b0}};
    end else begin
      ns_state_q <= ns_state_d;
      if (message_rx || ns_state_q != NS_ONLINE)
        idle_cnt_q <= {TIMEOUT_W{1'b0}};
      else
        idle_cnt_q <= idle_cnt_q + 1'b1;
    end
  end

  // lamp colour selection; the lamp test comes first
  // precedence, highest first: lamp test, fatal or conflict red, then state
  // a fatal error paints both lamps red so the pair reads as one alarm
  // a minor fault only touches the health lamp, the network lamp is kept
  always @* begin
    case (ns_state_q)
      NS_WAIT_MSG: ns_lamp_d = flash_ph_q ? `LAMP_GREEN : `LAMP_OFF;
      NS_ONLINE:   ns_lamp_d = `LAMP_GREEN;
      NS_TIMEOUT:  ns_lamp_d = flash_ph_q ? `LAMP_RED : `LAMP_OFF;
      default:     ns_lamp_d = `LAMP_OFF;
    endcase
    if (ip_conflict || fatal_error)
      ns_lamp_d = `LAMP_RED;
    if (fatal_error)
      ms_lamp_d = `LAMP_RED;
    else if (minor_fault)
      ms_lamp_d = flash_ph_q ? `LAMP_RED : `LAMP_OFF;
    else
      ms_lamp_d = `LAMP_GREEN;
    if (test_q) begin
      ns_lamp_d = `LAMP_BOTH;
      ms_lamp_d = `LAMP_BOTH;
    end
  end

  // registered lamp and speed outputs
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      first_port_led          <= 1'b0;
      second_port_led         <= 1'b0;
      first_port_speed        <= `SPEED_100;
      second_port_speed       <= `SPEED_100;
      network_state_indicator <= `LAMP_OFF;
      module_health_indicator <= `LAMP_OFF;
    end else begin
      first_port_led          <= link_lamp(first_port_link, first_port_activity, act_ph_q);
      second_port_led         <= link_lamp(second_port_link, second_port_activity, act_ph_q);
      first_port_speed        <= first_port_partner_fast ? `SPEED_100 : `SPEED_10;
      second_port_speed       <= second_port_partner_fast ? `SPEED_100 : `SPEED_10;
      network_state_indicator <= ns_lamp_d;
      module_health_indicator <= ms_lamp_d;
    end
  end

  // identity and network parameters; the hardware address has no write path
  // the address is reloaded from parameters on every clock, so even an upset
  // flip-flop heals within one cycle; reset shows zero for a single window
  // network words accept the full 32-bit range; checking them against
  // addressing rules is left to the configuring software
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hw_addr <= 48'h0;
      ip_addr <= `DEF_IP_ADDR;
      netmask <= `DEF_NETMASK;
      gateway <= `DEF_GATEWAY;
    end else begin
      hw_addr[`HW_ADDR_PREFIX_MSB:`HW_ADDR_PREFIX_LSB] <= MANUFACTURER_PREFIX;
      hw_addr[`HW_ADDR_SERIAL_MSB:`HW_ADDR_SERIAL_LSB] <= UNIT_SERIAL;
      if (factory_restore) begin
        ip_addr <= `DEF_IP_ADDR;
        netmask <= `DEF_NETMASK;
        gateway <= `DEF_GATEWAY;
      end else if (cfg_we) begin
        ip_addr <= cfg_ip_addr;
        netmask <= cfg_netmask;
        gateway <= cfg_gateway;
      end
    end
  end

endmodule

`default_nettype wire

// file: tb/status_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module status_monitor #(
  parameter [23:0] MANUFACTURER_PREFIX = 24'h000000,
  parameter [23:0] UNIT_SERIAL         = 24'h000000
) (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        first_port_link,
  input wire logic        first_port_activity,
  input wire logic        first_port_partner_fast,
  input wire logic        second_port_link,
  input wire logic        second_port_activity,
  input wire logic        fatal_error,
  input wire logic        first_port_led,
  input wire logic        second_port_led,
  input wire logic        first_port_speed,
  input wire logic [1:0]  network_state_indicator,
  input wire logic [1:0]  module_health_indicator,
  input wire logic [47:0] hw_addr
);
  // one clock domain, so one clocking and one disable for all
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_dark; !first_port_link && !first_port_activity |=> !first_port_led; endproperty
  a_dark: assert property (p_dark) else $error("port lamp lit while idle");
  property p_steady; first_port_link && !first_port_activity |=> first_port_led; endproperty
  a_steady: assert property (p_steady) else $error("port lamp not steady");
  // tuned for a two-cycle blink half period, as the bench builds it
  property p_blink; first_port_activity [*5] |-> first_port_led != $past(first_port_led, 2); endproperty
  a_blink: assert property (p_blink) else $error("port lamp not blinking");
  property p_second; second_port_link && !second_port_activity |=> second_port_led; endproperty
  a_second: assert property (p_second) else $error("second lamp not steady");
  // lamp test also carries the red bit, so this holds during startup
  property p_fatal; fatal_error [*3] |-> network_state_indicator[1] && module_health_indicator[1]; endproperty
  a_fatal: assert property (p_fatal) else $error("fatal not red on both");
  property p_test; $rose(rstn) |=> network_state_indicator == 2'b11 && module_health_indicator == 2'b11; endproperty
  a_test: assert property (p_test) else $error("no lamp test");
  property p_speed; 1'b1 |=> first_port_speed == $past(first_port_partner_fast); endproperty
  a_speed: assert property (p_speed) else $error("speed wrong");
  property p_addr; $past(rstn) |-> hw_addr == {MANUFACTURER_PREFIX, UNIT_SERIAL}; endproperty
  a_addr: assert property (p_addr) else $error("hardware address changed");
  c_online: cover property (network_state_indicator == 2'b01);
  c_fatal: cover property (fatal_error && module_health_indicator == 2'b10);
  c_blink: cover property (first_port_activity && $fell(first_port_led));
endmodule
bind encoder_network_status_leds status_monitor #(.MANUFACTURER_PREFIX(MANUFACTURER_PREFIX),
  .UNIT_SERIAL(UNIT_SERIAL)) mon (.*);
`default_nettype wire

// file: tb/link_partner.sv
`timescale 1ns/1ns
`default_nettype none
module link_partner (
  input wire logic clk,
  output var logic link,
  output var logic activity,
  output var logic fast,
  output var logic msg
);
  initial {link, activity, fast, msg} = 4'h0;
  // levels change just after an edge, like a real phy status
  task automatic set_port(input logic l, input logic a, input logic f);
    @(posedge clk);
    {link, activity, fast} <= {l, a, f};
  endtask
  // one message is one clock of pulse
  task automatic send_msg;
    @(posedge clk);
    msg <= 1'b1;
    @(posedge clk);
    msg <= 1'b0;
  endtask
endmodule
`default_nettype wire

// file: tb/encoder_network_status_leds_tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, a) begin total_checks++; if ((a) !== (e)) begin mismatches++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module encoder_network_status_leds_tb;
  localparam [23:0] PFX = 24'h3c3c3c; // arbitrary
  localparam [23:0] SER = 24'h000abc; // arbitrary
  logic clk, rstn, ip_valid, ip_conflict, fatal_error, minor_fault, cfg_we, factory_restore, message_rx, spare;
  logic first_port_link, first_port_activity, first_port_partner_fast, first_port_led, first_port_speed;
  logic second_port_link, second_port_activity, second_port_partner_fast, second_port_led, second_port_speed;
  logic [31:0] timeout_cycles, cfg_ip_addr, cfg_netmask, cfg_gateway, ip_addr, netmask, gateway;
  logic [1:0] network_state_indicator, module_health_indicator;
  logic [47:0] hw_addr;
  int mismatches, total_checks;
  encoder_network_status_leds #(.MANUFACTURER_PREFIX(PFX), .UNIT_SERIAL(SER), .ACT_HALF(2), .FLASH_HALF(4),
    .LAMP_TEST(10)) dut (.*);
  link_partner p1 (.clk(clk), .link(first_port_link), .activity(first_port_activity),
    .fast(first_port_partner_fast), .msg(message_rx));
  link_partner p2 (.clk(clk), .link(second_port_link), .activity(second_port_activity),
    .fast(second_port_partner_fast), .msg(spare));
  initial clk = 1'b0;
  always #20 clk = ~clk;
  // sample on falling edges so registered outputs have settled
  task automatic hold(input int n);
    repeat (n) @(negedge clk);
  endtask
  // collect every lamp code shown over n cycles; a flash shows two codes
  task automatic seen(input int n, input bit h, output logic [3:0] s);
    s = 4'h0;
    repeat (n) begin
      @(negedge clk);
      s[h ? module_health_indicator : network_state_indicator] = 1'b1;
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic t_startup;
    hold(2);
    `CHK("ns test", 2'b11, network_state_indicator)
    `CHK("ms test", 2'b11, module_health_indicator)
    `CHK("ip", 32'hc0a8010a, ip_addr)
    `CHK("mask", 32'hffffff00, netmask)
    `CHK("gw", 32'h00000000, gateway)
    `CHK("hw addr", {PFX, SER}, hw_addr)
    hold(12);
  endtask
  task automatic t_ports;
    logic a;
    p1.set_port(1'b0, 1'b0, 1'b0);
    hold(2);
    `CHK("p1 off", 1'b0, first_port_led)
    `CHK("p1 slow", 1'b0, first_port_speed)
    p1.set_port(1'b1, 1'b1, 1'b1);
    hold(3);
    a = first_port_led;
    hold(2);
    `CHK("p1 blink", ~a, first_port_led)
    `CHK("p1 fast", 1'b1, first_port_speed)
    p1.set_port(1'b1, 1'b0, 1'b1);
    p2.set_port(1'b1, 1'b0, 1'b0);
    hold(2);
    `CHK("p1 idle", 1'b1, first_port_led)
    `CHK("p2 idle", 1'b1, second_port_led)
    `CHK("p2 slow", 1'b0, second_port_speed)
    p2.set_port(1'b1, 1'b1, 1'b1);
    hold(3);
    a = second_port_led;
    hold(2);
    `CHK("p2 blink", ~a, second_port_led)
  endtask
  task automatic t_net;
    logic [3:0] s;
    @(posedge clk);
    ip_valid <= 1'b1;
    hold(3);
    seen(16, 0, s);
    `CHK("ns waiting", 4'b0011, s)
    p1.send_msg;
    hold(3);
    seen(8, 0, s);
    `CHK("ns online", 4'b0010, s)
    @(posedge clk);
    timeout_cycles <= 32'h00000006;
    hold(10);
    seen(16, 0, s);
    `CHK("ns timeout", 4'b0101, s)
    @(posedge clk);
    ip_conflict <= 1'b1;
    hold(3);
    seen(8, 0, s);
    `CHK("ns conflict", 4'b0100, s)
    @(posedge clk);
    ip_conflict <= 1'b0;
    fatal_error <= 1'b1;
    hold(3);
    seen(8, 1, s);
    `CHK("ms fatal", 4'b0100, s)
    `CHK("ns fatal", 2'b10, network_state_indicator)
    @(posedge clk);
    fatal_error <= 1'b0;
    minor_fault <= 1'b1;
    hold(3);
    seen(16, 1, s);
    `CHK("ms minor", 4'b0101, s)
    @(posedge clk);
    minor_fault <= 1'b0;
    ip_valid <= 1'b0;
    hold(3);
    seen(8, 1, s);
    `CHK("ms normal", 4'b0010, s)
    `CHK("ns no addr", 2'b00, network_state_indicator)
  endtask
  // settings arrive only as a software write, never from a pin
  task automatic t_cfg;
    @(posedge clk);
    {cfg_we, cfg_ip_addr, cfg_netmask, cfg_gateway} <= {1'b1, 32'hffffffff, 32'h00000000, 32'hffffffff};
    @(posedge clk);
    cfg_we <= 1'b0;
    hold(2);
    `CHK("cfg ip", 32'hffffffff, ip_addr)
    `CHK("cfg gw", 32'hffffffff, gateway)
    `CHK("hw fixed", {PFX, SER}, hw_addr)
    @(posedge clk);
    factory_restore <= 1'b1;
    @(posedge clk);
    factory_restore <= 1'b0;
    hold(2);
    `CHK("restored ip", 32'hc0a8010a, ip_addr)
    `CHK("restored mask", 32'hffffff00, netmask)
  endtask
  initial begin
    {rstn, ip_valid, ip_conflict, fatal_error, minor_fault, cfg_we, factory_restore} = 7'h00;
    {timeout_cycles, cfg_ip_addr, cfg_netmask, cfg_gateway} = 128'h0;
    mismatches = 0;
    total_checks = 0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    t_startup;
    t_ports;
    t_net;
    t_cfg;
    close_out;
  end
endmodule
`default_nettype wire
